// >>> rtl/amc_pkg.sv
/*
  Package for the converter mode register bank: register addresses, field
  positions, reset values, frame layout and power-state codes.
  Assumes a single system clock domain; the serial link is sampled.
*/
package amc_pkg;

  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned ADDR_BITS    = 7;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned CNT_BITS     = 5;

  localparam logic [6:0]  ADDR_SOFT_RESET    = 7'h00;
  localparam logic [6:0]  ADDR_POWER_DOWN    = 7'h01;
  localparam logic [6:0]  ADDR_OUTPUT_TIMING = 7'h02;

  localparam int unsigned SOFT_RESET_BIT     = 7;
  localparam int unsigned PWR_SEL_LSB        = 0;
  localparam int unsigned STROBE_INVERT_BIT  = 3;
  localparam int unsigned STROBE_PHASE_LSB   = 1;
  localparam int unsigned DUTY_STAB_BIT      = 0;

  localparam logic [1:0]  PWR_RESET_VALUE    = 2'h0;
  localparam logic [3:0]  TIMING_RESET_VALUE = 4'h0;

  // phase delay in eighths of the sample period, per code
  localparam logic [2:0]  PHASE_EIGHTHS_0 = 3'h0;
  localparam logic [2:0]  PHASE_EIGHTHS_1 = 3'h1;
  localparam logic [2:0]  PHASE_EIGHTHS_2 = 3'h2;
  localparam logic [2:0]  PHASE_EIGHTHS_3 = 3'h3;

  // sleep hold after soft reset, given in ns and rounded up to system clocks
  localparam int unsigned SLEEP_HOLD_NS     = 80;
  localparam int unsigned SYS_CLK_NS        = 8;
  localparam int unsigned SLEEP_HOLD_CYCLES = (SLEEP_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_CH2_NAP,
    PWR_BOTH_NAP,
    PWR_SLEEP
  } amc_power_type;

  typedef struct packed {
    logic       power_ch1_nap;
    logic       power_ch2_nap;
    logic       power_sleep;
    logic       sample_strobe_invert;
    logic [2:0] phase_eighths;
    logic       duty_stabilizer_enable;
  } amc_mode_type;

endpackage : amc_pkg

// >>> rtl/amc_regs.sv
/*
  Serial-programmed mode register bank of a dual-channel converter.
  Assumes the serial pins (chip select, clock, data in) come from outside
  the sys_clk domain; each is synchronised and clock edges are detected.
  The serial clock must be well below sys_clk/2 (bench: 80 ns period).
*/
// Overview of operation
// R1: writing a one to bit 7 of register 00h clears every mode register to zero.
// R2: a software reset also forces the converter into sleep for a short hold.
// R3: the software reset clears itself once the sleep hold that follows the frame that set it runs out.
// R4: register 00h is write-only and its readback is not to be relied on.
// R5: unused bits of registers 00h, 01h and 02h are ignored on write.
// R6: power field of 01h selects normal, channel 2 nap, both nap, or sleep.
// R7: bit 3 of 02h inverts the output sample strobe.
// R8: bits 2-1 of 02h delay the output strobe by 0, 1/8, 1/4 or 3/8 period.
// R9: the host must enable the duty stabilizer whenever it uses a phase delay.
// R10: bit 0 of 02h switches the duty cycle stabilizer on or off.
// R11: a frame is 16 bits: read/write flag, 7 address bits msb first, 8 data bits.
// R12: a frame starts on chip select low, takes 16 rising edges, ends on chip select high.
// R13: a read drives the register on the serial output and changes nothing.
// R14: the host's first frame after power-up must be a software reset.
// R15: unused bits of readable registers read back as zero.
`timescale 1ns/1ps
module amc_regs (
  input  wire logic          sys_clk,      // 125 MHz system clock
  input  wire logic          srst,         // sync reset, high
  input  wire logic          clk_en,       // freezes all state when low
  input  wire logic          cs_n,         // serial chip select, low active
  input  wire logic          sck,          // serial clock
  input  wire logic          sdi,          // serial data in
  output logic               sdo_o,        // open-drain data out (always 0)
  output logic               sdo_oe_n,     // low while pulling sdo low
  output amc_pkg::amc_mode_type mode,      // decoded mode controls
  output logic [1:0]         power_state_select, // raw power field
  output logic               soft_reset_active   // sleep forced by soft reset
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } amc_state_type;

  typedef struct packed {
    amc_state_type                 st;
    logic [amc_pkg::CNT_BITS-1:0]  cnt;
    logic [amc_pkg::FRAME_BITS-1:0] shreg;
    logic                          sck_prev;
    logic                          rd;
    logic [7:0]                    rd_data;
    logic                          reset_pend;
    logic [7:0]                    hold_cnt;
    logic [1:0]                    pwr;
    logic [3:0]                    timing;
    logic                          sdo_oe_n;
    amc_pkg::amc_mode_type         mode;
    logic                          srst_act;
  } amc_regs_state_type;

  amc_regs_state_type s_q;
  amc_regs_state_type s_d;

  logic cs_n_s;
  logic sck_s;
  logic sdi_s;

  amc_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );
  amc_sync #(.RESET_LEVEL(1'b0)) u_sync_sck (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .async_in(sck),
    .sync_out(sck_s)
  );
  amc_sync #(.RESET_LEVEL(1'b0)) u_sync_sdi (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .async_in(sdi),
    .sync_out(sdi_s)
  );

  logic                       sck_rise;
  logic                       sck_fall;
  logic [amc_pkg::FRAME_BITS-1:0] frame_nxt;
  logic [6:0]                 f_addr;
  logic [7:0]                 f_data;

  assign sck_rise  = sck_s & ~s_q.sck_prev;
  assign sck_fall  = ~sck_s & s_q.sck_prev;
  assign frame_nxt = {s_q.shreg[amc_pkg::FRAME_BITS-2:0], sdi_s};
  assign f_addr    = s_q.shreg[14:8];
  assign f_data    = s_q.shreg[7:0];

  always_comb begin
    s_d          = s_q;
    s_d.sck_prev = sck_s;
    // reset bit is never stored; only the sleep hold lingers
    // countdown first so a fresh soft reset below wins over expiry
    if (s_q.reset_pend) begin
      if (s_q.hold_cnt == 8'h00) begin
        s_d.reset_pend = 1'b0; // R3
      end else begin
        s_d.hold_cnt = s_q.hold_cnt - 8'h01;
      end
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.sdo_oe_n = 1'b1;
        if (!cs_n_s) begin // R12
          s_d.st    = ST_SHIFT;
          s_d.cnt   = '0;
          s_d.rd    = 1'b0;
          s_d.shreg = '0;
        end
      end
      ST_SHIFT: begin
        if (cs_n_s) begin
          s_d.st       = ST_IDLE; // short frame: discarded
          s_d.sdo_oe_n = 1'b1; // R12
        end else if (sck_rise) begin
          s_d.shreg = frame_nxt; // R11
          s_d.cnt   = s_q.cnt + amc_pkg::CNT_BITS'(1);
          // after the address byte, capture the readback word
          if (s_q.cnt == amc_pkg::CNT_BITS'(7)) begin
            s_d.rd = frame_nxt[7]; // R11
            case (frame_nxt[6:0])
              amc_pkg::ADDR_POWER_DOWN:    s_d.rd_data = {6'h00, s_q.pwr}; // R15
              amc_pkg::ADDR_OUTPUT_TIMING: s_d.rd_data = {4'h0, s_q.timing}; // R15
              default:                     s_d.rd_data = 8'h00; // R4
            endcase
          end
          if (s_q.cnt == amc_pkg::CNT_BITS'(amc_pkg::FRAME_BITS - 1)) begin
            s_d.st = ST_DONE; // R12
          end
        end else if (sck_fall && s_q.rd && s_q.cnt >= amc_pkg::CNT_BITS'(8)) begin
          // open drain: pull low for a zero, release for a one
          s_d.sdo_oe_n = s_q.rd_data[7]; // R13
          s_d.rd_data  = {s_q.rd_data[6:0], 1'b0};
        end
      end
      ST_DONE: begin
        if (cs_n_s) begin // R12
          s_d.st       = ST_IDLE;
          s_d.sdo_oe_n = 1'b1;
          if (!s_q.rd) begin // R13
            case (f_addr)
              amc_pkg::ADDR_SOFT_RESET: begin
                if (f_data[amc_pkg::SOFT_RESET_BIT]) begin // R5
                  s_d.pwr        = amc_pkg::PWR_RESET_VALUE; // R1
                  s_d.timing     = amc_pkg::TIMING_RESET_VALUE; // R1
                  s_d.reset_pend = 1'b1; // R3
                  s_d.hold_cnt   = 8'(amc_pkg::SLEEP_HOLD_CYCLES); // R2
                end
              end
              amc_pkg::ADDR_POWER_DOWN:    s_d.pwr    = f_data[1:0]; // R5
              amc_pkg::ADDR_OUTPUT_TIMING: s_d.timing = f_data[3:0]; // R5
              default: ;
            endcase
          end
        end else if (sck_fall && s_q.rd) begin
          s_d.sdo_oe_n = s_q.rd_data[7]; // R13
          s_d.rd_data  = {s_q.rd_data[6:0], 1'b0};
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    s_d.srst_act = s_d.reset_pend; // R2

    s_d.mode.power_sleep   = (s_d.pwr == 2'(amc_pkg::PWR_SLEEP)) | s_d.reset_pend; // R6 R2
    s_d.mode.power_ch2_nap = (s_d.pwr == 2'(amc_pkg::PWR_CH2_NAP)) |
                             (s_d.pwr == 2'(amc_pkg::PWR_BOTH_NAP)); // R6
    s_d.mode.power_ch1_nap = (s_d.pwr == 2'(amc_pkg::PWR_BOTH_NAP)); // R6
    s_d.mode.sample_strobe_invert   = s_d.timing[amc_pkg::STROBE_INVERT_BIT]; // R7
    s_d.mode.duty_stabilizer_enable = s_d.timing[amc_pkg::DUTY_STAB_BIT]; // R10
    case (s_d.timing[amc_pkg::STROBE_PHASE_LSB +: 2]) // R8
      2'h0:    s_d.mode.phase_eighths = amc_pkg::PHASE_EIGHTHS_0;
      2'h1:    s_d.mode.phase_eighths = amc_pkg::PHASE_EIGHTHS_1;
      2'h2:    s_d.mode.phase_eighths = amc_pkg::PHASE_EIGHTHS_2;
      default: s_d.mode.phase_eighths = amc_pkg::PHASE_EIGHTHS_3;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.sdo_oe_n <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign sdo_o              = 1'b0;
  assign sdo_oe_n           = s_q.sdo_oe_n;
  assign mode               = s_q.mode;
  assign power_state_select = s_q.pwr;
  assign soft_reset_active  = s_q.srst_act;

  AST_SLEEP_ON_RESET: assert property (@(posedge sys_clk) disable iff (srst) // R1 R2
    $rose(s_q.reset_pend) |-> s_q.mode.power_sleep && s_q.pwr == 2'h0 && s_q.timing == 4'h0)
    else $error("soft reset did not clear and sleep");
  AST_RESET_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (srst || !clk_en) // R3
    $rose(s_q.reset_pend) |-> ##[1:20] !s_q.reset_pend)
    else $error("soft reset hold did not end");
  AST_SLEEP_DECODE: assert property (@(posedge sys_clk) disable iff (srst) // R6
    s_q.pwr == 2'h3 |-> s_q.mode.power_sleep)
    else $error("sleep code not decoded");
  AST_NAP_DECODE: assert property (@(posedge sys_clk) disable iff (srst) // R6
    s_q.mode.power_ch1_nap |-> s_q.mode.power_ch2_nap && s_q.pwr == 2'h2)
    else $error("nap decode wrong");
  AST_INVERT: assert property (@(posedge sys_clk) disable iff (srst) // R7
    s_q.mode.sample_strobe_invert == s_q.timing[3])
    else $error("strobe invert mismatch");
  AST_PHASE: assert property (@(posedge sys_clk) disable iff (srst) // R8
    s_q.mode.phase_eighths == {1'b0, s_q.timing[2:1]})
    else $error("phase code mismatch");
  AST_DUTY: assert property (@(posedge sys_clk) disable iff (srst) // R10
    s_q.mode.duty_stabilizer_enable == s_q.timing[0])
    else $error("duty stabilizer mismatch");
  AST_READ_NO_WRITE: assert property (@(posedge sys_clk) disable iff (srst) // R13
    (s_q.st == ST_DONE && s_q.rd) |=> $stable(s_q.pwr) && $stable(s_q.timing))
    else $error("read changed a register");
  AST_SDO_IDLE: assert property (@(posedge sys_clk) disable iff (srst) // R13
    (s_q.st == ST_IDLE) |=> (s_q.st != ST_IDLE) || s_q.sdo_oe_n)
    else $error("sdo driven outside read");
  AST_SDO_READ_ONLY: assert property (@(posedge sys_clk) disable iff (srst) // R13
    !s_q.sdo_oe_n |-> s_q.rd && s_q.st != ST_IDLE)
    else $error("sdo pulled low outside a read");
  AST_SHIFT_COUNT: assert property (@(posedge sys_clk) disable iff (srst) // R12
    s_q.st == ST_SHIFT |-> s_q.cnt < 5'h10)
    else $error("more than 16 bits taken");

endmodule : amc_regs

// >>> rtl/amc_sync.sv
/*
  Two-stage synchroniser for one level from outside the system clock.
  Assumes the destination clock is sys_clk; first stage read only by second.
*/
`timescale 1ns/1ps
module amc_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic srst,     // sync reset, high
  input  wire logic clk_en,   // clock enable
  input  wire logic async_in, // asynchronous level
  output logic      sync_out  // synchronised level
);

  logic meta_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q   <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : amc_sync

// >>> tb/amc_host.sv
/*
  Behavioural serial host that frames 16-bit words into the mode bank.
  Assumes sys_clk paces it; sck is about 80 ns and idles low between frames.
*/
`timescale 1ns/1ps
module amc_host (
  input  wire logic sys_clk, // system clock
  input  wire logic sdo,     // resolved data out line
  output logic      cs_n,    // chip select, low active
  output logic      sck,     // serial clock
  output logic      sdi      // serial data in
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end

  // rises below or above 16 model a faulty host on purpose
  task automatic frame(input logic [15:0] w, input int rises, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge sys_clk) cs_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    for (int i = 0; i < rises; i++) begin
      sdi <= (i < 16) ? w[15-i] : ~sdi;
      repeat (5) @(posedge sys_clk);
      sck <= 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo};
      repeat (5) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    repeat (8) @(posedge sys_clk);
  endtask : frame
endmodule : amc_host

// >>> tb/amc_regs_tb.sv
/*
  Self-checking bench for the mode register bank, driven by the serial host.
  Assumes the host model in amc_host.sv and a pull-up on the data out line.
*/
`timescale 1ns/1ps
module amc_regs_tb;
  logic                  sys_clk, srst, clk_en, cs_n, sck, sdi, sdo, sdo_o, sdo_oe_n, soft_reset_active;
  logic [1:0]            power_state_select, pw;
  logic [3:0]            tm;
  logic [7:0]            rd, tv;
  amc_pkg::amc_mode_type mode;
  int                    num_errors = 0;
  int                    num_checks = 0;

  assign sdo = sdo_oe_n ? 1'b1 : sdo_o; // external pull-up
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  amc_regs amc_regs_i (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .mode(mode),
    .power_state_select(power_state_select), .soft_reset_active(soft_reset_active));
  amc_host amc_host_i (.sys_clk(sys_clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    amc_host_i.frame({1'b0, a, d}, 16, rd);
  endtask : wr

  task automatic rdr(input logic [6:0] a, output logic [7:0] d);
    amc_host_i.frame({1'b1, a, 8'hA5}, 16, d);
  endtask : rdr

  function automatic amc_pkg::amc_mode_type expm(input logic [1:0] p, input logic [3:0] t);
    return {p == 2'h2, p == 2'h1 || p == 2'h2, p == 2'h3, t[3], 1'b0, t[2:1], t[0]};
  endfunction : expm

  // registers and mode against the bench's own copy, then readback of both
  task automatic chk_all;
    check({power_state_select, mode}, {pw, expm(pw, tm)});
    rdr(7'h01, rd);
    check(rd, {6'h00, pw});
    rdr(7'h02, rd);
    check(rd, {4'h0, tm});
  endtask : chk_all

  task automatic sres;
    wr(7'h00, 8'h80);
    check({soft_reset_active, mode.power_sleep}, 2'h3);
    repeat (12) @(posedge sys_clk);
    check({soft_reset_active, power_state_select, mode}, 11'h000);
    pw = 2'h0;
    tm = 4'h0;
  endtask : sres

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    srst   = 1'b1;
    clk_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({sdo_oe_n, soft_reset_active, power_state_select, mode}, 12'h800);
    sres();
    for (int p = 0; p < 4; p++) begin
      pw = p[1:0];
      wr(7'h01, {6'h3F, pw});
      chk_all();
    end
    for (int k = 0; k < 8; k++) begin
      tv = {4'hA, k[2], k[1:0], k[1:0] != 2'h0 || k[2]};
      tm = tv[3:0];
      wr(7'h02, tv);
      chk_all();
    end
    amc_host_i.frame({1'b0, 7'h01, 8'h02}, 10, rd);
    check(power_state_select, pw);
    amc_host_i.frame({1'b0, 7'h01, 8'h02}, 18, rd);
    pw = 2'h2;
    chk_all();
    wr(7'h05, 8'hFF);
    rdr(7'h05, rd);
    check(rd, 8'h00);
    chk_all();
    rdr(7'h00, rd);
    check(rd, 8'h00);
    wr(7'h00, 8'h7F);
    check({soft_reset_active, power_state_select}, {1'b0, pw});
    sres();
    wr(7'h01, 8'h01);
    pw = 2'h1;
    check(soft_reset_active, 1'b0);
    chk_all();
    clk_en <= 1'b0;
    wr(7'h01, 8'h03);
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_all();
    // mid-run reset must drop the power field written above
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({sdo_oe_n, soft_reset_active, power_state_select, mode}, 12'h800);
    stop_test();
  end
endmodule : amc_regs_tb
